// File: rtl/spio_params.svh
// Overview of operation
// - Per shared pin, a mux pair picks peripheral or port as owner of output data and enable.
// - While an enabled peripheral actively drives a pin the port driver is off, pin still readable.
// - An enabled peripheral that is not driving lets the port drive the pin from its latch.
// - Port output never loops through into the input of a peripheral on the same pin.
// - Direction bit one makes the pin an input, zero makes it an output driven from the latch.
// - On any reset every pin direction is set to input.
// - Reading the latch register returns the latch, writing it updates the latch.
// - Reading the pin-state register returns pin levels, writing it updates the latch.
// - Unimplemented port bits read zero in latch, direction and pin state.
// - A pin shared only with input functions is treated as a dedicated port pin.
// - First remap register bits 12-8 select pin 19 output function, bits 4-0 pin 18.
// - Second remap register bits 12-8 select pin 21 output function, bits 4-0 pin 20.
// - Remap register bits 15-13 and 7-5 are unimplemented and read zero.
`ifndef SPIO_PARAMS_SVH
`define SPIO_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SPIO_OFF_DIR       8'h00
`define SPIO_OFF_LAT       8'h04
`define SPIO_OFF_PIN       8'h08
`define SPIO_OFF_RMP_A     8'h0C
`define SPIO_OFF_RMP_B     8'h10

// ************************************************************
// Field positions and reset values
// ************************************************************
`define SPIO_SEL_W         5
`define SPIO_SEL_LO_POS    0
`define SPIO_SEL_HI_POS    8
`define SPIO_DIR_RST       16'hFFFF
`define SPIO_LAT_RST       16'h0000
`define SPIO_SEL_RST       5'h00
`define SPIO_RMP_BASE      18
`define SPIO_NUM_RMP       4

`endif

// File: rtl/spio_pkg.sv
package spio_pkg;
   typedef logic [4:0] spio_sel_t;

   // Register bus request carried as one bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } spio_wb_req_s;

   // Selector fields of the remap registers
   typedef struct packed {
      spio_sel_t sel19;
      spio_sel_t sel18;
      spio_sel_t sel21;
      spio_sel_t sel20;
   } spio_rmp_s;

   typedef enum logic [0:0] {
      SPIO_IDLE = 1'b0,
      SPIO_ACK  = 1'b1
   } spio_bus_e;
endpackage

// File: rtl/spio_pin_mux.sv
`include "spio_params.svh"
// ************************************************************
// One pin: port versus peripheral ownership
// ************************************************************
module spio_pin_mux
   import spio_pkg::*;
(
   input  wire logic dir_i,
   input  wire logic lat_i,
   input  wire logic per_en_i,
   input  wire logic per_drv_i,
   input  wire logic per_out_i,
   input  wire logic pad_in_i,
   output logic      pad_out_o,
   output logic      pad_oe_o,
   output logic      per_in_o
);
   logic per_owns;

   // Peripheral owns only when enabled and driving
   assign per_owns  = per_en_i & per_drv_i;
   assign pad_out_o = per_owns ? per_out_i : lat_i;
   assign pad_oe_o  = per_owns ? 1'b1 : ~dir_i;
   // Block loop-through while the port itself drives
   assign per_in_o  = (pad_oe_o & ~per_owns) ? 1'b0 : pad_in_i;
endmodule

// File: rtl/spio_remap.sv
`include "spio_params.svh"
// ************************************************************
// Remap selector decode for one pin
// ************************************************************
module spio_remap
   import spio_pkg::*;
#(
   parameter int NUM_FUNC = 8
)
(
   input  wire logic                sel_i,
   input  wire logic [NUM_FUNC-1:0] func_en_i,
   input  wire logic [NUM_FUNC-1:0] func_drv_i,
   input  wire logic [NUM_FUNC-1:0] func_out_i,
   input  wire spio_sel_t           code_i,
   output logic                     en_o,
   output logic                     drv_o,
   output logic                     out_o
);
   // Zero and out-of-range codes connect nothing
   always_comb
   begin
      en_o  = 1'b0;
      drv_o = 1'b0;
      out_o = 1'b0;
      if (sel_i && code_i != `SPIO_SEL_RST && int'(code_i) <= NUM_FUNC)
      begin
         en_o  = func_en_i[int'(code_i) - 1];
         drv_o = func_drv_i[int'(code_i) - 1];
         out_o = func_out_i[int'(code_i) - 1];
      end
   end
endmodule

// File: rtl/spio_port.sv
`include "spio_params.svh"
// ************************************************************
// Shared-pin I/O port with remappable outputs, Wishbone slave
// ************************************************************
module spio_port
   import spio_pkg::*;
#(
   parameter int          WIDTH     = 22,
   parameter logic [21:0] IMPL_MASK = 22'h3FFFFF,
   parameter int          NUM_FUNC  = 8
)
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic [WIDTH-1:0]    per_en_i,
   input  wire logic [WIDTH-1:0]    per_drv_i,
   input  wire logic [WIDTH-1:0]    per_out_i,
   input  wire logic [NUM_FUNC-1:0] func_en_i,
   input  wire logic [NUM_FUNC-1:0] func_drv_i,
   input  wire logic [NUM_FUNC-1:0] func_out_i,
   input  wire logic [WIDTH-1:0]    pad_in_i,
   output logic [WIDTH-1:0]         pad_out_o,
   output logic [WIDTH-1:0]         pad_oe_o,
   output logic [WIDTH-1:0]         per_in_o
);
   // ************************************************************
   // State
   // ************************************************************
   spio_wb_req_s      req;
   spio_bus_e         bus_st;
   spio_rmp_s         rmp;
   logic [WIDTH-1:0]  dir;
   logic [WIDTH-1:0]  lat;
   logic [WIDTH-1:0]  mask;
   logic [WIDTH-1:0]  own_en;
   logic [WIDTH-1:0]  own_drv;
   logic [WIDTH-1:0]  own_out;
   logic [WIDTH-1:0]  raw_oe;
   logic [WIDTH-1:0]  pin_rd;
   logic              wr_go;
   logic [31:0]       wmask;
   logic [31:0]       next_dat;

   assign req  = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};
   assign mask = IMPL_MASK[WIDTH-1:0];

   // Byte-lane expansion, used for direction and latch writes
   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // Merge a write into a stored word under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   assign wmask = lanes(req.sel);
   // Write takes effect on the acking edge only
   assign wr_go = req.cyc & req.stb & req.we & (bus_st == SPIO_ACK);

   // ************************************************************
   // Bus handshake: one wait cycle, ack pulse
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bus_st <= SPIO_IDLE;
      else
      begin
         case (bus_st)
            SPIO_IDLE: if (req.cyc && req.stb) bus_st <= SPIO_ACK;
            SPIO_ACK:  bus_st <= SPIO_IDLE;
            default:   bus_st <= SPIO_IDLE;
         endcase
      end
   end
   assign wb_ack_o = (bus_st == SPIO_ACK);

   // ************************************************************
   // Direction register
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dir <= WIDTH'(`SPIO_DIR_RST) | {WIDTH{1'b1}};
      else if (wr_go && req.adr == `SPIO_OFF_DIR)
         dir <= WIDTH'(merge(32'(dir), 32'(req.dat), wmask)) | ~mask;
   end

   // ************************************************************
   // Output latch, written through latch or pin-state offset
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lat <= WIDTH'(`SPIO_LAT_RST);
      else if (wr_go && (req.adr == `SPIO_OFF_LAT || req.adr == `SPIO_OFF_PIN))
         lat <= WIDTH'(merge(32'(lat), 32'(req.dat), wmask)) & mask;
   end

   // ************************************************************
   // Remap selectors; unimplemented bits never stored
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rmp <= '{default: `SPIO_SEL_RST};
      else if (wr_go && req.adr == `SPIO_OFF_RMP_A)
      begin
         if (req.sel[1]) rmp.sel19 <= req.dat[12:8];
         if (req.sel[0]) rmp.sel18 <= req.dat[4:0];
      end
      else if (wr_go && req.adr == `SPIO_OFF_RMP_B)
      begin
         if (req.sel[1]) rmp.sel21 <= req.dat[12:8];
         if (req.sel[0]) rmp.sel20 <= req.dat[4:0];
      end
   end

   // ************************************************************
   // Ownership sources: remap decode on pins 18-21, fixed elsewhere
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_pin
         if (g >= `SPIO_RMP_BASE && g < `SPIO_RMP_BASE + `SPIO_NUM_RMP)
         begin : g_rmp
            spio_sel_t code;
            assign code = (g == 18) ? rmp.sel18 : (g == 19) ? rmp.sel19 :
                          (g == 20) ? rmp.sel20 : rmp.sel21;
            spio_remap #(.NUM_FUNC(NUM_FUNC)) u_rmp (
               .sel_i      (1'b1),
               .func_en_i  (func_en_i),
               .func_drv_i (func_drv_i),
               .func_out_i (func_out_i),
               .code_i     (code),
               .en_o       (own_en[g]),
               .drv_o      (own_drv[g]),
               .out_o      (own_out[g])
            );
         end
         else
         begin : g_fix
            // Input-only sharers tie drv low: dedicated port pin
            assign own_en[g]  = per_en_i[g];
            assign own_drv[g] = per_drv_i[g];
            assign own_out[g] = per_out_i[g];
         end
         spio_pin_mux u_mux (
            .dir_i     (dir[g]),
            .lat_i     (lat[g]),
            .per_en_i  (own_en[g]),
            .per_drv_i (own_drv[g]),
            .per_out_i (own_out[g]),
            .pad_in_i  (pad_in_i[g]),
            .pad_out_o (pad_out_o[g]),
            .pad_oe_o  (raw_oe[g]),
            .per_in_o  (per_in_o[g])
         );
      end
   endgenerate

   // Absent bits never drive
   assign pad_oe_o = raw_oe & mask;
   assign pin_rd   = pad_in_i & mask;

   // ************************************************************
   // Read mux, registered; unmapped reads zero
   // ************************************************************
   always_comb
   begin
      next_dat = 32'h0000_0000;
      case (req.adr)
         `SPIO_OFF_DIR:   next_dat = 32'(dir & mask);
         `SPIO_OFF_LAT:   next_dat = 32'(lat);
         `SPIO_OFF_PIN:   next_dat = 32'(pin_rd);
         `SPIO_OFF_RMP_A: next_dat = {19'h0, rmp.sel19, 3'h0, rmp.sel18};
         `SPIO_OFF_RMP_B: next_dat = {19'h0, rmp.sel21, 3'h0, rmp.sel20};
         default:         next_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (bus_st == SPIO_IDLE && req.cyc && req.stb && !req.we)
         wb_dat_o <= next_dat;
   end
endmodule

// File: tb/spio_port_sva.sv
`include "spio_params.svh"
// ********
// Bus and pin ownership checks
// ********
module spio_port_chk
   import spio_pkg::*;
#(
   parameter int          WIDTH     = 22,
   parameter logic [21:0] IMPL_MASK = 22'h3FFFFF,
   parameter int          NUM_FUNC  = 8
)
(
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [7:0]       wb_adr_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic [WIDTH-1:0] per_en_i,
   input wire logic [WIDTH-1:0] per_drv_i,
   input wire logic [WIDTH-1:0] per_out_i,
   input wire logic [WIDTH-1:0] pad_in_i,
   input wire logic [WIDTH-1:0] pad_out_o,
   input wire logic [WIDTH-1:0] pad_oe_o,
   input wire logic [WIDTH-1:0] per_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [21:0] own;
   // Fixed pins held by a driving peripheral; remap pins ignore these inputs
   assign own = per_en_i & per_drv_i & 22'h03FFFF & IMPL_MASK;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_periph_own: assert property (
      ((pad_oe_o & own) == own) && (((pad_out_o ^ per_out_i) & own) == 22'h000000))
      else $error("peripheral lost its pin");
   a_loop_block: assert property (
      (per_in_o & pad_oe_o & ~own & 22'h03FFFF) == 22'h000000)
      else $error("port output loops into peripheral");
   a_in_pass: assert property (
      ((per_in_o ^ pad_in_i) & ~pad_oe_o & IMPL_MASK) == 22'h000000)
      else $error("pin level not passed on");
   a_absent_off: assert property ((pad_oe_o & ~IMPL_MASK) == 22'h000000)
      else $error("absent pin drives");
   a_reset_input: assert property ($fell(rst_i) |-> (pad_oe_o & ~own) == 22'h000000)
      else $error("pin not input after reset");
   a_remap_gap: assert property (
      wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == `SPIO_OFF_RMP_A
      || $past(wb_adr_i) == `SPIO_OFF_RMP_B) |-> (wb_dat_o & 32'hFFFFE0E0) == 32'h0)
      else $error("remap gap bits not zero");
   a_absent_read: assert property (
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) < `SPIO_OFF_RMP_A
      |-> (wb_dat_o & ~{10'h000, IMPL_MASK}) == 32'h0)
      else $error("absent bit reads one");
endmodule

bind spio_port spio_port_chk #(.WIDTH(WIDTH), .IMPL_MASK(IMPL_MASK), .NUM_FUNC(NUM_FUNC))
   i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .per_en_i(per_en_i), .per_drv_i(per_drv_i), .per_out_i(per_out_i), .pad_in_i(pad_in_i),
   .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .per_in_o(per_in_o));

// File: tb/spio_pin_env.sv
// ********
// Board side of the pins
// ********
module spio_pin_env
(
   input  wire logic [21:0] pad_out_i,
   input  wire logic [21:0] pad_oe_i,
   input  wire logic [21:0] ext_i,
   output logic      [21:0] pad_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Chip wins where it drives, board level elsewhere
   assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// File: tb/tb_shared_pin_io_port_with_output_remap.sv
`include "spio_params.svh"
// ********
// Port bench: bus, pin mux and remap
// ********
module tb_shared_pin_io_port_with_output_remap;
   import spio_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [21:0] IM = 22'h3FFF7F; // Pin 7 absent
   logic clk_i, rst_i, ack;
   spio_wb_req_s req;
   logic [31:0] dat_o, q, v, d;
   logic [21:0] per_en, per_drv, per_out, ext, pad_out, pad_oe, pad_in, own, oe, pin, pe, pd, po;
   logic [7:0]  func_en, func_drv, func_out;
   logic [21:0] pi; // Peripheral-side view of the pins
   int fails, cmp_count;
   spio_port #(.IMPL_MASK(IM)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc),
      .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
      .wb_dat_i(req.dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .per_en_i(per_en),
      .per_drv_i(per_drv), .per_out_i(per_out), .func_en_i(func_en), .func_drv_i(func_drv),
      .func_out_i(func_out), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
      .per_in_o(pi));
   spio_pin_env i_env (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pad_in_o(pad_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; held until ack is seen at an edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw,
                     output logic [31:0] dr);
      int n;
      req <= '{1'b1, 1'b1, we, 4'hF, a, dw};
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      dr = dat_o;
      if (n == 20)
         fails++;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Free-running system clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Hang guard, far beyond the expected run
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      final_report();
   end
   initial
   begin
      {rst_i, req, per_en, per_drv, per_out, func_en, func_drv, func_out, ext} = '1;
      req = '0;
      fails = 0;
      cmp_count = 0;
      v = $urandom(32'hFE09);
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, `SPIO_OFF_DIR, 32'h0, q); chk(q, {10'h000, IM});
      wb(1'b0, `SPIO_OFF_LAT, 32'h0, q); chk(q, 32'h0);
      wb(1'b0, `SPIO_OFF_RMP_B, 32'h0, q); chk(q, 32'h0);
      func_en <= 8'h00;
      repeat (8)
      begin
         v = $urandom;
         d = $urandom;
         pe = 22'($urandom);
         pd = 22'($urandom);
         po = 22'($urandom);
         per_en <= pe;
         per_drv <= pd;
         per_out <= po;
         ext <= 22'($urandom);
         wb(1'b1, `SPIO_OFF_LAT, v, q);
         wb(1'b1, `SPIO_OFF_DIR, d, q);
         wb(1'b0, `SPIO_OFF_LAT, 32'h0, q); chk(q, v & {10'h000, IM});
         own = pe & pd & 22'h03FFFF;
         oe = (~d[21:0] | own) & IM;
         pin = (oe & ((own & po) | (~own & v[21:0]))) | (~oe & ext);
         chk({10'h000, pad_oe}, {10'h000, oe});
         chk({10'h000, pi}, {10'h000, pin & ~(~d[21:0] & ~own & IM)});
         wb(1'b0, `SPIO_OFF_PIN, 32'h0, q); chk(q, {10'h000, pin & IM});
         wb(1'b1, `SPIO_OFF_PIN, ~v, q);
         wb(1'b0, `SPIO_OFF_LAT, 32'h0, q); chk(q, ~v & {10'h000, IM});
      end
      // Remap: codes 1, 2, 8 pick functions, 9 is out of range
      per_en <= '0;
      func_en <= 8'hFF;
      func_drv <= 8'hFF;
      func_out <= 8'($urandom);
      // All inputs, so only a selected function can enable a remap pin
      wb(1'b1, `SPIO_OFF_DIR, 32'hFFFFFFFF, q);
      wb(1'b1, `SPIO_OFF_RMP_A, 32'hFFFFE2E1, q);
      wb(1'b0, `SPIO_OFF_RMP_A, 32'h0, q); chk(q, 32'h00000201);
      wb(1'b1, `SPIO_OFF_RMP_B, 32'h00000809, q);
      wb(1'b0, `SPIO_OFF_RMP_B, 32'h0, q); chk(q, 32'h00000809);
      v = ~v;
      chk(pad_out[21:18], {func_out[7], v[20], func_out[1:0]});
      chk(pad_oe[21:18], 4'hB);
      func_drv <= 8'h00;
      @(posedge clk_i);
      @(posedge clk_i);
      chk(pad_out[21:18], v[21:18]);
      chk(pad_oe[21:18], 4'h0);
      wb(1'b1, 8'h20, 32'hFFFFFFFF, q);
      wb(1'b0, 8'h20, 32'h0, q); chk(q, 32'h0);
      wb(1'b1, `SPIO_OFF_DIR, 32'h0, q);
      wb(1'b0, `SPIO_OFF_DIR, 32'h0, q); chk(q, 32'h0);
      // Mid-run reset must put every pin back to input
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, `SPIO_OFF_DIR, 32'h0, q); chk(q, {10'h000, IM});
      wb(1'b0, `SPIO_OFF_RMP_A, 32'h0, q); chk(q, 32'h0);
      chk({10'h000, pad_oe}, 32'h0);
      final_report();
   end
endmodule
